// ### src/mcs_pkg.sv
// Shared constants and types of the module control and status logic
package mcs_pkg;
	// ======== Timing
	localparam longint CLK_HZ     = 64'd100_000_000;
	localparam longint NR_TIME_MS = 64'd20;
	localparam int     NR_CYC     = int'(NR_TIME_MS * CLK_HZ / 64'd1000);
	localparam int     RST_CYC    = 16;
	// ======== Management bus
	localparam logic [6:0] TARGET_ADDR = 7'h50;
	// ======== Register offsets
	localparam logic [7:0] OFF_CTRL  = 8'h00;
	localparam logic [7:0] OFF_STATE = 8'h04;
	localparam logic [7:0] OFF_IRQ_S = 8'h08;
	localparam logic [7:0] OFF_IRQ_C = 8'h0c;
	localparam logic [7:0] OFF_IRQ_E = 8'h10;
	// ======== Fields and resets
	localparam int EV_NR_SET  = 0;
	localparam int EV_LOS_SET = 1;
	localparam int EV_PD_FALL = 2;
	localparam int EV_NR_CLR  = 3;
	localparam int CTRL_SOFT_OFF = 0;
	localparam int CTRL_SOFT_LP  = 1;
	localparam logic [1:0] CTRL_RST = 2'h0;
	localparam logic [3:0] ENA_RST  = 4'h0;
	localparam logic [7:0] PIN_INIT = 8'h1f;
	// ======== Types
	typedef struct packed {
		logic rx_low;
		logic rx_lol;
		logic tx_lol;
		logic sda;
		logic scl;
		logic desel;
		logic pd;
		logic laser;
	} mcs_pins_t;
	typedef enum logic [6:0] {
		I2C_IDLE  = 7'h01,
		I2C_ADDR  = 7'h02,
		I2C_ACK_A = 7'h04,
		I2C_RD    = 7'h08,
		I2C_RACK  = 7'h10,
		I2C_WR    = 7'h20,
		I2C_ACK_W = 7'h40
	} mcs_i2c_st_t;
endpackage

// ### src/mcs_sync.sv
// Two-stage synchroniser for a group of pin levels
`timescale 1ns/1ps
module mcs_sync #(
	parameter int              W    = 8,
	parameter logic [W-1:0]    INIT = '0
) (
	input  wire logic         pclk,
	input  wire logic         presetn,
	input  wire logic [W-1:0] d,
	output logic      [W-1:0] q
);
	typedef struct packed {
		logic [W-1:0] s1;
		logic [W-1:0] s2;
	} mcs_sync_t;
	mcs_sync_t s_reg, s_next;
	// Shift through both stages
	always_comb begin
		s_next.s1 = d;
		s_next.s2 = s_reg.s1;
	end
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s_reg <= {INIT, INIT};
		end else begin
			s_reg <= s_next;
		end
	end
	assign q = s_reg.s2;
endmodule

// ### src/mcs_i2c.sv
// Two-wire management target: address match, byte read, byte write
`timescale 1ns/1ps
module mcs_i2c (
	input  wire logic       pclk,
	input  wire logic       presetn,
	input  wire logic       scl,
	input  wire logic       sda,
	input  wire logic       en,
	input  wire logic [7:0] rd_byte,
	output logic            sda_oe,
	output logic            wr_stb,
	output logic      [7:0] wr_byte
);
	typedef struct packed {
		mcs_pkg::mcs_i2c_st_t st;
		logic                 scl_q;
		logic                 sda_q;
		logic [7:0]           sh;
		logic [3:0]           cnt;
		logic                 oe;
		logic                 stb;
	} mcs_i2c_t;
	mcs_i2c_t s_reg, s_next;
	logic start, stop, rise, fall;
	// Bus conditions from sampled lines
	assign start = scl & s_reg.scl_q & s_reg.sda_q & !sda;
	assign stop  = scl & s_reg.scl_q & !s_reg.sda_q & sda;
	assign rise  = scl & !s_reg.scl_q;
	assign fall  = !scl & s_reg.scl_q;
	// Byte engine, bits change on falling clock
	always_comb begin
		s_next = s_reg;
		s_next.scl_q = scl;
		s_next.sda_q = sda;
		s_next.stb = 1'b0;
		if (!en || stop) begin
			s_next.st = mcs_pkg::I2C_IDLE;
			s_next.oe = 1'b0;
		end else if (start) begin
			s_next.st = mcs_pkg::I2C_ADDR;
			s_next.cnt = 4'h0;
			s_next.oe = 1'b0;
		end else begin
			// Count data bits only; acknowledge clocks keep the byte intact
			if (rise && (s_reg.st == mcs_pkg::I2C_ADDR || s_reg.st == mcs_pkg::I2C_RD
				|| s_reg.st == mcs_pkg::I2C_WR)) begin
				s_next.cnt = s_reg.cnt + 4'h1;
				if (s_reg.st != mcs_pkg::I2C_RD) begin
					s_next.sh = {s_reg.sh[6:0], sda};
				end
			end
			case (s_reg.st)
				mcs_pkg::I2C_ADDR: begin
					if (fall && s_reg.cnt == 4'h8) begin
						if (s_reg.sh[7:1] == mcs_pkg::TARGET_ADDR) begin
							s_next.st = mcs_pkg::I2C_ACK_A;
							s_next.oe = 1'b1;
						end else begin
							s_next.st = mcs_pkg::I2C_IDLE;
						end
					end
				end
				mcs_pkg::I2C_ACK_A: begin
					if (fall) begin
						s_next.cnt = 4'h0;
						if (s_reg.sh[0]) begin
							s_next.st = mcs_pkg::I2C_RD;
							s_next.sh = rd_byte;
							s_next.oe = !rd_byte[7];
						end else begin
							s_next.st = mcs_pkg::I2C_WR;
							s_next.oe = 1'b0;
						end
					end
				end
				mcs_pkg::I2C_RD: begin
					if (fall && s_reg.cnt == 4'h8) begin
						s_next.st = mcs_pkg::I2C_RACK;
						s_next.oe = 1'b0;
					end else if (fall) begin
						s_next.sh = {s_reg.sh[6:0], 1'b0};
						s_next.oe = !s_reg.sh[6];
					end
				end
				mcs_pkg::I2C_RACK: begin
					if (rise) begin
						s_next.st = sda ? mcs_pkg::I2C_IDLE : mcs_pkg::I2C_ACK_A;
						s_next.sh = 8'h01;
					end
				end
				mcs_pkg::I2C_WR: begin
					if (fall && s_reg.cnt == 4'h8) begin
						s_next.st = mcs_pkg::I2C_ACK_W;
						s_next.oe = 1'b1;
						s_next.stb = 1'b1;
					end
				end
				mcs_pkg::I2C_ACK_W: begin
					if (fall) begin
						s_next.st = mcs_pkg::I2C_WR;
						s_next.cnt = 4'h0;
						s_next.oe = 1'b0;
					end
				end
				default: begin
					s_next.st = mcs_pkg::I2C_IDLE;
				end
			endcase
		end
	end
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s_reg <= {mcs_pkg::I2C_IDLE, 1'b1, 1'b1, 8'h00, 4'h0, 1'b0, 1'b0};
		end else begin
			s_reg <= s_next;
		end
	end
	assign sda_oe  = s_reg.oe;
	assign wr_stb  = s_reg.stb;
	assign wr_byte = s_reg.sh;
endmodule

// ### src/mcs_ctl.sv
// Control and status pins of a pluggable optical module, with APB registers
// Summary of operation
// - While laser_off is high the transmitter is off, otherwise it runs; here it also stays off on the soft off bit, low power or module reset.
// - Undriven laser_off and powerdown_reset read high, so the module starts dark and low power.
// - The management target answers only while module_deselect is low.
// - The management target answers at seven-bit address 1010000, last bit read or write.
// - attention_n is pulled low while a condition is latched, and the cause is readable over the management bus.
// - absent_flag is tied low inside the module.
// - not_ready_flag is high on an operational fault and low otherwise.
// - The fault is the OR of transmit lock lost and receive lock lost.
// - not_ready_flag follows a fault change within the 20 ms response time.
// - optical_loss_flag is high while received power is too low.
// - While powerdown_reset is high the module stays in limited power mode.
// - Each falling edge of powerdown_reset performs a full module reset.
// - The reference clock inputs are ignored.
//
// The APB slave port and the register addresses are this design's own decisions.
`timescale 1ns/1ps
module mcs_ctl #(
	parameter int NR_CYC  = mcs_pkg::NR_CYC,
	parameter int RST_CYC = mcs_pkg::RST_CYC
) (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic [7:0]  paddr,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic        laser_off,
	input  wire logic        powerdown_reset,
	input  wire logic        module_deselect,
	input  wire logic        scl_in,
	input  wire logic        sda_in,
	output logic             sda_out,
	output logic             sda_oe,
	input  wire logic        tx_lol,
	input  wire logic        rx_lol,
	input  wire logic        rx_power_low,
	input  wire logic        ref_clk_pos,
	input  wire logic        ref_clk_neg,
	output logic             tx_enable,
	output logic             low_power,
	output logic             module_reset,
	output logic             not_ready_flag,
	output logic             optical_loss_flag,
	output logic             absent_flag,
	output logic             attention_n_out,
	output logic             attention_n_oe,
	output logic             irq
);
	// ========================================
	// Local state
	localparam int CW = $clog2(NR_CYC + 1);
	localparam int RW = $clog2(RST_CYC + 1);
	typedef struct packed {
		logic [31:0]   rdata;
		logic          slverr;
		logic [1:0]    ctrl;
		logic [3:0]    sts;
		logic [3:0]    ena;
		logic          nr;
		logic [CW-1:0] nr_cnt;
		logic          los_q;
		logic          pd_q;
		logic [RW-1:0] rst_cnt;
	} mcs_state_t;
	mcs_state_t        s_reg, s_next;
	mcs_pkg::mcs_pins_t pin;
	logic [7:0]        pin_raw;
	logic              raw_fault;
	logic              pd_fall;
	logic              resetting;
	logic              i2c_en;
	logic              i2c_oe;
	logic              i2c_stb;
	logic [7:0]        i2c_wbyte;
	logic [7:0]        i2c_rbyte;
	logic [3:0]        ev;
	logic              setup;
	logic              access;

	// ========================================
	// Pin capture
	// Reference clock pins are left unread
	assign pin_raw = {rx_power_low, rx_lol, tx_lol, sda_in, scl_in,
		module_deselect, powerdown_reset, laser_off};
	// Start with laser off and low power until pins are sampled
	mcs_sync #(
		.W    (8),
		.INIT (mcs_pkg::PIN_INIT)
	) u_sync (
		.pclk    (pclk),
		.presetn (presetn),
		.d       (pin_raw),
		.q       (pin)
	);

	// ========================================
	// Management target
	// Off while deselected or during module reset
	assign i2c_en = !pin.desel && !resetting;
	// Cause byte: live fault sources and latched conditions
	assign i2c_rbyte = {pin.rx_low, pin.rx_lol, pin.tx_lol, s_reg.nr, s_reg.sts};
	mcs_i2c u_i2c (
		.pclk    (pclk),
		.presetn (presetn),
		.scl     (pin.scl),
		.sda     (pin.sda),
		.en      (i2c_en),
		.rd_byte (i2c_rbyte),
		.sda_oe  (i2c_oe),
		.wr_stb  (i2c_stb),
		.wr_byte (i2c_wbyte)
	);

	// ========================================
	// Control and status logic
	assign raw_fault = pin.tx_lol | pin.rx_lol;
	assign pd_fall   = s_reg.pd_q & !pin.pd;
	assign resetting = s_reg.rst_cnt != '0;
	assign setup     = psel & !penable;
	assign access    = psel & penable;

	// Next state of every register
	always_comb begin
		s_next = s_reg;
		s_next.pd_q = pin.pd;
		s_next.los_q = pin.rx_low;
		// Fault must persist a full response window
		if (raw_fault != s_reg.nr) begin
			if (s_reg.nr_cnt == CW'(NR_CYC - 1)) begin
				s_next.nr = raw_fault;
				s_next.nr_cnt = '0;
			end else begin
				s_next.nr_cnt = s_reg.nr_cnt + CW'(1);
			end
		end else begin
			s_next.nr_cnt = '0;
		end
		// Reset timer on power-down release
		if (pd_fall) begin
			s_next.rst_cnt = RW'(RST_CYC);
		end else if (resetting) begin
			s_next.rst_cnt = s_reg.rst_cnt - RW'(1);
		end
		// Events
		ev = '0;
		ev[mcs_pkg::EV_NR_SET] = !s_reg.nr & s_next.nr;
		ev[mcs_pkg::EV_NR_CLR] = s_reg.nr & !s_next.nr;
		ev[mcs_pkg::EV_LOS_SET] = !s_reg.los_q & pin.rx_low;
		ev[mcs_pkg::EV_PD_FALL] = pd_fall;
		// APB read data captured in setup
		if (setup) begin
			s_next.rdata = '0;
			s_next.slverr = 1'b0;
			case (paddr)
				mcs_pkg::OFF_CTRL: begin
					s_next.rdata[1:0] = s_reg.ctrl;
				end
				mcs_pkg::OFF_STATE: begin
					s_next.rdata[5:0] = {pin.desel, resetting, pin.rx_low,
						s_reg.nr, low_power, tx_enable};
				end
				mcs_pkg::OFF_IRQ_S: begin
					s_next.rdata[3:0] = s_reg.sts;
				end
				mcs_pkg::OFF_IRQ_C: begin
					s_next.rdata = '0;
				end
				mcs_pkg::OFF_IRQ_E: begin
					s_next.rdata[3:0] = s_reg.ena;
				end
				default: begin
					s_next.slverr = 1'b1;
				end
			endcase
		end
		// Sticky status: clear by APB or by management write, set wins
		s_next.sts = s_reg.sts;
		if (i2c_stb) begin
			s_next.sts = s_next.sts & ~i2c_wbyte[3:0];
		end
		if (access && pwrite && !s_reg.slverr) begin
			case (paddr)
				mcs_pkg::OFF_CTRL: begin
					s_next.ctrl = pwdata[1:0];
				end
				mcs_pkg::OFF_IRQ_C: begin
					s_next.sts = s_next.sts & ~pwdata[3:0];
				end
				mcs_pkg::OFF_IRQ_E: begin
					s_next.ena = pwdata[3:0];
				end
				default: begin
					s_next.ena = s_reg.ena;
				end
			endcase
		end
		s_next.sts = s_next.sts | ev;
		// Full module reset clears control
		if (resetting) begin
			s_next.ctrl = mcs_pkg::CTRL_RST;
		end
	end

	// State register
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s_reg <= {32'h0000_0000, 1'b0, mcs_pkg::CTRL_RST, 4'h0,
				mcs_pkg::ENA_RST, 1'b0, CW'(0), 1'b0, 1'b1, RW'(0)};
		end else begin
			s_reg <= s_next;
		end
	end

	// ========================================
	// Outputs
	// No wait states, read data was captured in the setup cycle
	assign pready  = 1'b1;
	assign prdata  = s_reg.rdata;
	assign pslverr = s_reg.slverr & access;
	// Transmitter dark on pin, soft bit, low power or reset
	assign low_power = pin.pd | s_reg.ctrl[mcs_pkg::CTRL_SOFT_LP];
	assign tx_enable = !pin.laser && !s_reg.ctrl[mcs_pkg::CTRL_SOFT_OFF]
		&& !low_power && !resetting;
	assign module_reset      = resetting;
	assign not_ready_flag    = s_reg.nr;
	assign optical_loss_flag = pin.rx_low;
	assign absent_flag       = 1'b0;
	// Open-collector lines, pull low while enabled
	assign sda_out         = 1'b0;
	assign sda_oe          = i2c_oe & !pin.desel;
	assign attention_n_out = 1'b0;
	assign attention_n_oe  = |s_reg.sts;
	assign irq             = |(s_reg.sts & s_reg.ena);

	// ========================================
	// Assertions
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	sequence seq_pd_fall;
		$fell(pin.pd);
	endsequence
	sequence seq_reset_run;
		module_reset [*4];
	endsequence
	sequence seq_new_event;
		ev != 4'h0;
	endsequence
	sequence seq_oe_rise;
		$rose(sda_oe);
	endsequence

	a_laser_off_dark: assert property (pin.laser |-> !tx_enable)
		else $error("transmitter on while laser_off high");
	a_powerdown_low: assert property (pin.pd |-> low_power && !tx_enable)
		else $error("not in low power while powerdown high");
	a_reset_on_fall: assert property (seq_pd_fall |=> seq_reset_run)
		else $error("no module reset after powerdown fall");
	a_absent_tied: assert property (!absent_flag)
		else $error("absent flag not low");
	a_deselect_quiet: assert property (pin.desel |-> !sda_oe ##1 !sda_oe)
		else $error("data line driven while deselected");
	a_desel_idle: assert property ($rose(pin.desel) |=> !i2c_oe)
		else $error("target active after deselect");
	a_nr_cause: assert property ($changed(not_ready_flag)
		|-> not_ready_flag == $past(raw_fault))
		else $error("not ready changed against fault");
	a_nr_window: assert property ((raw_fault != not_ready_flag)
		|-> s_reg.nr_cnt < CW'(NR_CYC))
		else $error("not ready response window overrun");
	a_nr_steady: assert property ((raw_fault == s_reg.nr) [*2]
		|-> $stable(not_ready_flag))
		else $error("not ready moved without fault change");
	a_los_follow: assert property ($rose(pin.rx_low)
		|-> optical_loss_flag ##1 attention_n_oe)
		else $error("loss of signal not flagged");
	a_attn_cause: assert property (attention_n_oe == (i2c_rbyte[3:0] != 4'h0))
		else $error("attention without readable cause");
	a_start_dark: assert property ($rose(presetn) |-> !tx_enable)
		else $error("transmitter on right after reset");

	// ========================================
	// Transmitter, power and module reset
	a_lp_dark: assert property (low_power |-> !tx_enable)
		else $error("transmitter on in low power mode");
	a_soft_off: assert property (s_reg.ctrl[mcs_pkg::CTRL_SOFT_OFF]
		|-> !tx_enable)
		else $error("transmitter on while soft off set");
	a_reset_dark: assert property (module_reset |-> !tx_enable)
		else $error("transmitter on during module reset");
	a_reset_ctrl: assert property (module_reset
		|=> s_reg.ctrl == mcs_pkg::CTRL_RST)
		else $error("control not cleared by module reset");

	// Management target silent while deselected or in reset
	a_reset_quiet: assert property (module_reset
		|=> !i2c_oe)
		else $error("target active during module reset");
	a_desel_off: assert property (pin.desel
		|=> !i2c_oe)
		else $error("target active while deselected");
	a_drive_enabled: assert property (seq_oe_rise
		|-> $past(i2c_en))
		else $error("data line driven while target disabled");

	// Sticky status, attention and interrupt
	a_event_sticks: assert property (seq_new_event
		|=> (s_reg.sts & $past(ev)) == $past(ev))
		else $error("event not latched in status");
	a_attn_on_event: assert property (seq_new_event
		|=> attention_n_oe)
		else $error("attention not pulled after event");
	a_irq_masked: assert property ((s_reg.ena == 4'h0)
		|-> !irq)
		else $error("interrupt with all sources masked");
	a_irq_enabled: assert property (((s_reg.sts & s_reg.ena) != 4'h0)
		|-> irq)
		else $error("interrupt missing for enabled status");

	// Fault filter and loss of signal
	a_nr_filter: assert property ($changed(not_ready_flag)
		|-> $past(s_reg.nr_cnt) == CW'(NR_CYC - 1))
		else $error("not ready changed before window ended");
	a_nr_restart: assert property ((raw_fault == s_reg.nr)
		|=> s_reg.nr_cnt == CW'(0))
		else $error("fault window not restarted");
	a_los_event: assert property ($rose(optical_loss_flag)
		|=> s_reg.sts[mcs_pkg::EV_LOS_SET])
		else $error("loss of signal event not latched");
endmodule

// ### testbench/mcs_host_model.sv
// Host-side two-wire controller model for the management bus
`timescale 1ns/1ps
module mcs_host_model (
	input  wire logic pclk,
	input  wire logic dev_sda_oe,
	output logic      scl,
	output logic      sda
);
	logic host_low;
	// Wired-and data line, host pull-up when released
	assign sda = !(host_low || dev_sda_oe);
	initial begin
		scl = 1'b1;
		host_low = 1'b0;
	end
	task automatic wt(input int n);
		repeat (n) @(posedge pclk);
	endtask
	// One clock pulse: drive a bit, sample the line mid-high
	task automatic bit_io(input logic drv, output logic smp);
		scl <= 1'b0;
		wt(4);
		host_low <= !drv;
		wt(4);
		scl <= 1'b1;
		wt(4);
		smp = sda;
		wt(4);
	endtask
	// Start, address byte, acknowledge, one read byte and nack if a read is acknowledged, stop
	task automatic xfer(input logic [7:0] a, output logic ack, output logic [7:0] d);
		logic s;
		host_low <= 1'b1;
		wt(8);
		for (int i = 7; i >= 0; i--) begin
			bit_io(a[i], s);
		end
		bit_io(1'b1, s);
		ack = !s;
		d = 8'h00;
		if (ack && a[0]) begin
			for (int i = 7; i >= 0; i--) begin
				bit_io(1'b1, s);
				d[i] = s;
			end
			bit_io(1'b1, s); // Nack ends the read
		end
		scl <= 1'b0;
		wt(4);
		host_low <= 1'b1;
		wt(4);
		scl <= 1'b1;
		wt(4);
		host_low <= 1'b0; // Stop
		wt(8);
	endtask
endmodule

// ### testbench/tb_module_control_status_pins.sv
// Self-checking bench of the module control and status logic
`timescale 1ns/1ps
module tb_module_control_status_pins;
	localparam int NR  = 20;
	localparam int RST = 16;
	logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err, ack;
	logic [7:0]  paddr, d;
	logic [6:0]  a7;
	logic [31:0] pwdata, prdata, rd;
	logic        laser_off, powerdown_reset, module_deselect, scl, sda, sda_oe;
	logic        tx_lol, rx_lol, rx_power_low, ref_clk_pos, ref_clk_neg;
	logic        tx_enable, low_power, module_reset, not_ready_flag;
	logic        optical_loss_flag, absent_flag, attention_n_oe, irq;
	logic [1:0]  f;
	logic        sda_lvl, attn_lvl;
	int          num_errors, n_compared, seed, k, drv_cnt;

	mcs_ctl #(.NR_CYC(NR), .RST_CYC(RST)) u_dut (
		.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
		.penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .laser_off(laser_off),
		.powerdown_reset(powerdown_reset), .module_deselect(module_deselect),
		.scl_in(scl), .sda_in(sda), .sda_out(sda_lvl), .sda_oe(sda_oe), .tx_lol(tx_lol),
		.rx_lol(rx_lol), .rx_power_low(rx_power_low), .ref_clk_pos(ref_clk_pos),
		.ref_clk_neg(ref_clk_neg), .tx_enable(tx_enable), .low_power(low_power),
		.module_reset(module_reset), .not_ready_flag(not_ready_flag),
		.optical_loss_flag(optical_loss_flag), .absent_flag(absent_flag),
		.attention_n_out(attn_lvl), .attention_n_oe(attention_n_oe), .irq(irq));
	mcs_host_model u_host (.pclk(pclk), .dev_sda_oe(sda_oe), .scl(scl), .sda(sda));

	// ========================================
	// Clock, reference clock noise, drive monitor
	initial begin
		pclk = 1'b0;
		forever #5 pclk = ~pclk;
	end
	always @(posedge pclk) begin
		ref_clk_pos <= ~ref_clk_pos;
		ref_clk_neg <= ref_clk_pos;
		if (module_deselect === 1'b1 && sda_oe !== 1'b0) begin
			drv_cnt <= drv_cnt + 1;
		end
	end
	initial begin
		repeat (100000) @(posedge pclk);
		chk("timeout", 0, 1);
		give_verdict();
	end

	// ========================================
	// Shared tasks
	task automatic wt(input int n);
		repeat (n) @(posedge pclk);
	endtask
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		n_compared++;
		if (g !== e) begin
			num_errors++;
			$display("BAD %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic give_verdict();
		$display("compared %0d mismatches %0d", n_compared, num_errors);
		if (num_errors == 0 && n_compared > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask
	// One APB transfer, waits for pready
	task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] wd);
		int n;
		psel    <= 1'b1;
		penable <= 1'b0;
		paddr   <= a;
		pwrite  <= w;
		pwdata  <= wd;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		if (n >= 20) begin
			chk("pready", 1, 0);
			give_verdict();
		end
		rd  = prdata;
		err = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask

	// ========================================
	// Main sequence
	initial begin
		seed = 32'h5e2e0fe2;
		num_errors = 0;
		n_compared = 0;
		drv_cnt = 0;
		{presetn, psel, penable, pwrite, paddr, pwdata} = '0;
		{laser_off, powerdown_reset, module_deselect} = 3'h7;
		{tx_lol, rx_lol, rx_power_low, ref_clk_pos, ref_clk_neg} = 5'h01;
		wt(4);
		presetn <= 1'b1;
		wt(4);
		chk("tx_enable", 0, tx_enable);
		chk("low_power", 1, low_power);
		chk("absent_flag", 0, absent_flag);
		chk("attn_level", 0, attn_lvl);
		chk("sda_level", 0, sda_lvl);
		$display("test reset done");
		// Power-down cycles with random laser control
		for (int i = 0; i < 4; i++) begin
			f = 2'($random(seed));
			powerdown_reset <= 1'b1;
			wt(6);
			chk("low_power", 1, low_power);
			powerdown_reset <= 1'b0;
			laser_off <= f[0];
			k = 0;
			repeat (40) begin
				@(posedge pclk);
				k += (module_reset === 1'b1);
			end
			chk("reset_len", RST, k);
			chk("low_power", 0, low_power);
			chk("tx_enable", !f[0], tx_enable);
		end
		$display("test pins done");
		// Fault combinations
		for (int i = 0; i < 8; i++) begin
			f = 2'($random(seed));
			tx_lol <= f[0];
			rx_lol <= f[1];
			rx_power_low <= f[0] ^ f[1];
			wt(NR + 8);
			chk("not_ready", f[0] | f[1], not_ready_flag);
			chk("los", f[0] ^ f[1], optical_loss_flag);
		end
		// Short glitch must be filtered out
		tx_lol <= ~tx_lol;
		wt(NR / 2);
		tx_lol <= ~tx_lol;
		wt(NR + 8);
		chk("nr_glitch", f[0] | f[1], not_ready_flag);
		$display("test faults done");
		// Interrupt: clear, event masked, enabled, cause read over two-wire
		apb(mcs_pkg::OFF_IRQ_E, 1'b1, 32'h0000_0000);
		apb(mcs_pkg::OFF_IRQ_C, 1'b1, 32'h0000_000f);
		apb(mcs_pkg::OFF_IRQ_S, 1'b0, 32'h0000_0000);
		chk("status", 0, rd);
		chk("attention", 0, attention_n_oe);
		powerdown_reset <= 1'b1;
		wt(6);
		powerdown_reset <= 1'b0;
		wt(40);
		apb(mcs_pkg::OFF_IRQ_S, 1'b0, 32'h0000_0000);
		chk("status", 32'h0000_0004, rd);
		chk("irq", 0, irq);
		chk("attention", 1, attention_n_oe);
		apb(mcs_pkg::OFF_IRQ_E, 1'b1, 32'h0000_0004);
		chk("irq", 1, irq);
		module_deselect <= 1'b0;
		wt(4);
		u_host.xfer(8'ha1, ack, d);
		chk("ack", 1, ack);
		chk("byte", {24'h0, f[0] ^ f[1], f[1], f[0], f[0] | f[1], 4'h4}, d);
		u_host.xfer(8'ha0, ack, d);
		chk("ack_wr", 1, ack);
		a7 = 7'($random(seed));
		a7 = (a7 == 7'h50) ? 7'h51 : a7;
		u_host.xfer({a7, 1'b1}, ack, d);
		chk("ack_other", 0, ack);
		module_deselect <= 1'b1;
		wt(4);
		k = drv_cnt;
		u_host.xfer(8'ha1, ack, d);
		chk("ack_desel", 0, ack);
		chk("drive_desel", k, drv_cnt);
		apb(mcs_pkg::OFF_IRQ_C, 1'b1, 32'h0000_0004);
		apb(mcs_pkg::OFF_IRQ_C, 1'b0, 32'h0000_0000);
		chk("clear_rd", 0, rd);
		chk("irq", 0, irq);
		chk("attention", 0, attention_n_oe);
		apb(8'h14, 1'b0, 32'h0000_0000);
		chk("slverr", 1, err);
		chk("unmapped", 0, rd);
		$display("test irq and two-wire done");
		// Soft control bits and state readback
		laser_off <= 1'b0;
		apb(mcs_pkg::OFF_CTRL, 1'b1, 32'h0000_0001);
		chk("soft_off", 0, tx_enable);
		apb(mcs_pkg::OFF_CTRL, 1'b0, 32'h0000_0000);
		chk("ctrl_rd", 1, rd);
		apb(mcs_pkg::OFF_CTRL, 1'b1, 32'h0000_0002);
		chk("soft_lp", 1, low_power);
		chk("lp_dark", 0, tx_enable);
		apb(mcs_pkg::OFF_CTRL, 1'b1, 32'h0000_0000);
		apb(mcs_pkg::OFF_STATE, 1'b0, 32'h0000_0000);
		chk("state", {26'h0, 1'b1, 1'b0, f[0] ^ f[1], f[0] | f[1], 2'b01}, rd);
		$display("test control register done");
		give_verdict();
	end
endmodule
